// ---- sdb_pkg.sv ----
// Shared constants and carrier types for the synthesizer divider and block standby logic
package sdb_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_PDOWN   = 8'h00;
    localparam logic [7:0] ADDR_REF_HI  = 8'h08;
    localparam logic [7:0] ADDR_REF_LO  = 8'h09;
    localparam logic [7:0] ADDR_CNT_HI  = 8'h0a;
    localparam logic [7:0] ADDR_MAIN_LO = 8'h0b;
    localparam logic [7:0] ADDR_PUMP    = 8'h0c;
    localparam logic [7:0] ADDR_FA_HI   = 8'h0d;
    localparam logic [7:0] ADDR_FA_LO   = 8'h0e;

    // Reset values
    localparam logic [7:0]  PDOWN_RST   = 8'hff;
    localparam logic [13:0] REF_RST     = 14'h0038;
    localparam logic [2:0]  SWALLOW_RST = 3'h5;
    localparam logic [12:0] MAIN_RST    = 13'h001d;
    localparam logic [11:0] FA_DIV_RST  = 12'h004;

    // Power-down register bit positions
    localparam int PD_REF    = 7;
    localparam int PD_MIXER  = 6;
    localparam int PD_OSC    = 5;
    localparam int PD_SAMPLE = 4;
    localparam int PD_GAIN   = 3;
    localparam int PD_FRONT  = 2;
    localparam int PD_CONV   = 0;

    // Field positions in the count and pump registers
    localparam int SWALLOW_LSB = 5;
    localparam int FAST_BIT    = 6;
    localparam int INV_BIT     = 5;
    localparam int CODE_LSB    = 2;

    // Prescaler moduli and pump scaling
    localparam logic [3:0] PRE_LOW_LAST  = 4'h7;
    localparam logic [3:0] PRE_HIGH_LAST = 4'h8;
    localparam logic [2:0] FA_LEVEL_MAX  = 3'h7;
    localparam int         PUMP_STEP_UA  = 625;

    typedef struct packed {
        logic [7:0]  pdown;
        logic [13:0] ref_div;
        logic [2:0]  swallow;
        logic [12:0] main;
        logic        fast;
        logic        invert;
        logic [2:0]  code;
        logic [1:0]  test;
        logic [11:0] fa_div;
    } sdb_cfg_type;

    typedef struct packed {
        logic ref_bias_off;
        logic mixer_synth_standby;
        logic oscillator_standby;
        logic sample_synth_standby;
        logic gain_dac_standby;
        logic front_end_standby;
        logic converter_standby;
        logic filter_clk_halt;
        logic dig_out_freeze;
        logic clock_buffer_off;
        logic master_ref_standby;
    } sdb_standby_type;

    typedef struct packed {
        logic       source;
        logic       sink;
        logic       oe;
        logic [3:0] units;
    } sdb_pump_type;

    typedef struct packed {
        logic sample_pump_oe;
        logic gain_out_pos_oe;
        logic gain_out_neg_oe;
        logic front_end_cap_a_oe;
        logic front_end_cap_b_oe;
        logic front_end_cap_c_oe;
        logic common_mode_out_oe;
    } sdb_pin_oe_type;

    typedef struct packed {
        sdb_cfg_type     cfg;
        sdb_standby_type sb;
        sdb_pin_oe_type  pin_oe;
        sdb_pump_type    pump;
        logic [7:0]      rdata;
        logic [2:0]      ref_sync;
        logic [2:0]      vco_sync;
        logic [3:0]      pre_cnt;
        logic [2:0]      swallow_left;
        logic [12:0]     main_left;
        logic            fb_evt;
        logic [2:0]      width_t;
        logic            was_active;
        logic [2:0]      fa_level;
    } sdb_state_type;

endpackage

// ---- sdb_divider.sv ----
// Programmable event divider: one output pulse per div input events
`timescale 1ns/1ns
module sdb_divider #(
    parameter int W = 14
) (
    // Clock and control
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic         clr,
    // Events and ratio
    input  wire logic         in_evt,
    input  wire logic [W-1:0] div,
    output logic              out_evt
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         pulse;
    } sdb_div_state_type;

    sdb_div_state_type st_r;
    sdb_div_state_type st_nxt;
    logic [W-1:0]      last;

    // A ratio of zero behaves as one so the detector never starves
    assign last = (div == '0) ? '0 : div - W'(1);

    always_comb begin
        st_nxt       = st_r;
        st_nxt.pulse = 1'b0;
        if (clr) begin
            st_nxt.cnt = '0;
        end else if (in_evt) begin
            if (st_r.cnt >= last) begin
                st_nxt.cnt   = '0;
                st_nxt.pulse = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign out_evt = st_r.pulse;

    a_div_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ce && !clr && in_evt && st_r.cnt >= last) |=> (out_evt && st_r.cnt == '0))
        else $error("divider did not wrap at its ratio");
endmodule

// ---- sdb_pfd.sv ----
// Phase-frequency detector: set on each input event, cleared when both are set
`timescale 1ns/1ns
module sdb_pfd (
    // Clock and control
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic clr,
    // Divided reference and feedback events
    input  wire logic ref_evt,
    input  wire logic fb_evt,
    // Detector outputs
    output logic      up,
    output logic      dn
);
    typedef struct packed {
        logic up;
        logic dn;
    } sdb_pfd_state_type;

    sdb_pfd_state_type st_r;
    sdb_pfd_state_type st_nxt;

    always_comb begin
        st_nxt.up = st_r.up | ref_evt;
        st_nxt.dn = st_r.dn | fb_evt;
        // Both caught up: the phase gap is closed, clear at once
        if (clr || (st_nxt.up && st_nxt.dn)) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign up = st_r.up;
    assign dn = st_r.dn;

    a_pfd_exclusive: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !(up && dn))
        else $error("detector raised both outputs");
    a_pfd_lead: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ce && !clr && ref_evt && !fb_evt && !dn) |=> up)
        else $error("leading reference did not raise up");
endmodule

// ---- sdb_synth.sv ----
// Integer-N synthesizer digital core with the block power-down register
//
// Contract
// - Power-down register resets to all ones
// - Clear bit wakes block; set bit sleeps
// - Bit 7 kills voltage reference and bias
// - Bit 6 stops synthesizer, floats its pump
// - Bit 5 stops the clock oscillator
// - Bit 3 stops gain DAC, floats outputs
// - Bit 2 stops front end, floats caps
// - Bit 0 stops converter, filter clock, outputs
// - All blocks asleep: master reference sleeps too
// - Reference divided by 14-bit count
// - Feedback divides by eight main plus swallow
// - Detector pulses track phase difference
// - Pump drives only while inputs differ
// - Pump current is code plus one steps
// - Fast acquire raises pump current automatically
// - Output frequency follows the division ratio
`timescale 1ns/1ns
module sdb_synth (
    // Clock, reset, enable
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire logic                     ce,
    // Register port
    input  wire logic                     reg_wr,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    output logic      [7:0]               reg_rdata,
    // Pins from the reference oscillator and the VCO
    input  wire logic                     ref_in,
    input  wire logic                     vco_in,
    // Charge pump of the mixer synthesizer
    output sdb_pkg::sdb_pump_type         mixer_pump_output,
    // Block standby controls and pin enables
    output sdb_pkg::sdb_standby_type      standby,
    output sdb_pkg::sdb_pin_oe_type       pin_oe
);
    localparam sdb_pkg::sdb_cfg_type CFG_RST = '{
        pdown:   sdb_pkg::PDOWN_RST,
        ref_div: sdb_pkg::REF_RST,
        swallow: sdb_pkg::SWALLOW_RST,
        main:    sdb_pkg::MAIN_RST,
        fast:    1'b0,
        invert:  1'b0,
        code:    3'h0,
        test:    2'h0,
        fa_div:  sdb_pkg::FA_DIV_RST
    };

    sdb_pkg::sdb_state_type st_r;
    sdb_pkg::sdb_state_type st_nxt;
    sdb_pkg::sdb_state_type st_rst;

    logic ref_evt;
    logic vco_evt;
    logic ref_tick;
    logic fa_tick;
    logic pfd_up;
    logic pfd_dn;
    logic pfd_active;
    logic synth_off;
    logic pre_end;
    logic main_end;

    // Standby decode; bit 1 is stored and read back but drives nothing
    function automatic sdb_pkg::sdb_standby_type decode_standby(input logic [7:0] pd);
        sdb_pkg::sdb_standby_type s;
        s.ref_bias_off         = pd[sdb_pkg::PD_REF];
        s.mixer_synth_standby  = pd[sdb_pkg::PD_MIXER];
        s.oscillator_standby   = pd[sdb_pkg::PD_OSC];
        s.sample_synth_standby = pd[sdb_pkg::PD_SAMPLE];
        s.gain_dac_standby     = pd[sdb_pkg::PD_GAIN];
        s.front_end_standby    = pd[sdb_pkg::PD_FRONT];
        s.converter_standby    = pd[sdb_pkg::PD_CONV];
        s.filter_clk_halt      = pd[sdb_pkg::PD_CONV];
        s.dig_out_freeze       = pd[sdb_pkg::PD_CONV];
        s.clock_buffer_off     = pd[sdb_pkg::PD_SAMPLE] & pd[sdb_pkg::PD_CONV];
        s.master_ref_standby   = &{pd[7:2], pd[sdb_pkg::PD_CONV]};
        return s;
    endfunction

    // A one in a bit powers the block down and floats its pins
    function automatic sdb_pkg::sdb_pin_oe_type decode_oe(input logic [7:0] pd);
        sdb_pkg::sdb_pin_oe_type o;
        o.sample_pump_oe     = !pd[sdb_pkg::PD_SAMPLE];
        o.gain_out_pos_oe    = !pd[sdb_pkg::PD_GAIN];
        o.gain_out_neg_oe    = !pd[sdb_pkg::PD_GAIN];
        o.front_end_cap_a_oe = !pd[sdb_pkg::PD_FRONT];
        o.front_end_cap_b_oe = !pd[sdb_pkg::PD_FRONT];
        o.front_end_cap_c_oe = !pd[sdb_pkg::PD_FRONT];
        o.common_mode_out_oe = !pd[sdb_pkg::PD_CONV];
        return o;
    endfunction

    function automatic logic [7:0] read_mux(input logic [7:0] a, input sdb_pkg::sdb_cfg_type c);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            sdb_pkg::ADDR_PDOWN:   d = c.pdown;
            sdb_pkg::ADDR_REF_HI:  d = {2'h0, c.ref_div[13:8]};
            sdb_pkg::ADDR_REF_LO:  d = c.ref_div[7:0];
            sdb_pkg::ADDR_CNT_HI:  d = {c.swallow, c.main[12:8]};
            sdb_pkg::ADDR_MAIN_LO: d = c.main[7:0];
            sdb_pkg::ADDR_PUMP:    d = {1'b0, c.fast, c.invert, c.code, c.test};
            sdb_pkg::ADDR_FA_HI:   d = {4'h0, c.fa_div[11:8]};
            sdb_pkg::ADDR_FA_LO:   d = c.fa_div[7:0];
            default:               d = 8'h00;
        endcase
        return d;
    endfunction

    // Units of the smallest pump step; fast acquire never lowers the nominal value
    function automatic logic [3:0] pump_units(input logic [2:0] code, input logic fast,
                                              input logic [2:0] level);
        logic [2:0] m;
        m = code;
        if (fast) begin
            if (m < 3'h1) begin
                m = 3'h1;
            end
            if (level > m) begin
                m = level;
            end
        end
        return {1'b0, m} + 4'h1;
    endfunction

    always_comb begin
        st_rst              = '0;
        st_rst.cfg          = CFG_RST;
        st_rst.sb           = decode_standby(sdb_pkg::PDOWN_RST);
        st_rst.pin_oe       = decode_oe(sdb_pkg::PDOWN_RST);
        st_rst.swallow_left = sdb_pkg::SWALLOW_RST;
        st_rst.main_left    = sdb_pkg::MAIN_RST;
        st_rst.pump.units   = 4'h1;
    end

    // Only the second and third stages are read; the first stage feeds the second alone
    assign ref_evt    = st_r.ref_sync[1] & ~st_r.ref_sync[2];
    assign vco_evt    = st_r.vco_sync[1] & ~st_r.vco_sync[2];
    assign synth_off  = st_r.cfg.pdown[sdb_pkg::PD_MIXER];
    assign pfd_active = pfd_up | pfd_dn;
    assign pre_end    = (st_r.swallow_left != 3'h0) ? (st_r.pre_cnt >= sdb_pkg::PRE_HIGH_LAST)
                                                    : (st_r.pre_cnt >= sdb_pkg::PRE_LOW_LAST);
    assign main_end   = (st_r.main_left <= 13'h0001);

    sdb_divider #(
        .W(14)
    ) u_ref_div (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ce      (ce),
        .clr     (synth_off),
        .in_evt  (ref_evt),
        .div     (st_r.cfg.ref_div),
        .out_evt (ref_tick)
    );

    // Interval timer for fast acquire, also counted from the raw reference
    sdb_divider #(
        .W(12)
    ) u_fa_div (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ce      (ce),
        .clr     (synth_off | ~st_r.cfg.fast),
        .in_evt  (ref_evt),
        .div     (st_r.cfg.fa_div),
        .out_evt (fa_tick)
    );

    sdb_pfd u_pfd (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ce      (ce),
        .clr     (synth_off),
        .ref_evt (ref_tick),
        .fb_evt  (st_r.fb_evt),
        .up      (pfd_up),
        .dn      (pfd_dn)
    );

    always_comb begin
        st_nxt          = st_r;
        st_nxt.ref_sync = {st_r.ref_sync[1:0], ref_in};
        st_nxt.vco_sync = {st_r.vco_sync[1:0], vco_in};
        st_nxt.fb_evt   = 1'b0;

        if (reg_wr) begin
            unique case (reg_addr)
                sdb_pkg::ADDR_PDOWN:   st_nxt.cfg.pdown = reg_wdata;
                sdb_pkg::ADDR_REF_HI:  st_nxt.cfg.ref_div[13:8] = reg_wdata[5:0];
                sdb_pkg::ADDR_REF_LO:  st_nxt.cfg.ref_div[7:0] = reg_wdata;
                sdb_pkg::ADDR_CNT_HI: begin
                    st_nxt.cfg.swallow    = reg_wdata[sdb_pkg::SWALLOW_LSB +: 3];
                    st_nxt.cfg.main[12:8] = reg_wdata[4:0];
                end
                sdb_pkg::ADDR_MAIN_LO: st_nxt.cfg.main[7:0] = reg_wdata;
                sdb_pkg::ADDR_PUMP: begin
                    st_nxt.cfg.fast   = reg_wdata[sdb_pkg::FAST_BIT];
                    st_nxt.cfg.invert = reg_wdata[sdb_pkg::INV_BIT];
                    st_nxt.cfg.code   = reg_wdata[sdb_pkg::CODE_LSB +: 3];
                    st_nxt.cfg.test   = reg_wdata[1:0];
                end
                sdb_pkg::ADDR_FA_HI:   st_nxt.cfg.fa_div[11:8] = reg_wdata[3:0];
                sdb_pkg::ADDR_FA_LO:   st_nxt.cfg.fa_div[7:0] = reg_wdata;
                default: ;
            endcase
        end
        st_nxt.sb     = decode_standby(st_nxt.cfg.pdown);
        st_nxt.pin_oe = decode_oe(st_nxt.cfg.pdown);
        st_nxt.rdata  = read_mux(reg_addr, st_nxt.cfg);

        // Feedback divider: 8/9 prescaler counted down by swallow and main counters
        if (synth_off) begin
            st_nxt.pre_cnt      = 4'h0;
            st_nxt.swallow_left = st_r.cfg.swallow;
            st_nxt.main_left    = st_r.cfg.main;
        end else if (vco_evt) begin
            if (pre_end) begin
                st_nxt.pre_cnt = 4'h0;
                if (main_end) begin
                    st_nxt.swallow_left = st_r.cfg.swallow;
                    st_nxt.main_left    = st_r.cfg.main;
                    st_nxt.fb_evt       = 1'b1;
                end else begin
                    st_nxt.main_left = st_r.main_left - 13'h0001;
                    if (st_r.swallow_left != 3'h0) begin
                        st_nxt.swallow_left = st_r.swallow_left - 3'h1;
                    end
                end
            end else begin
                st_nxt.pre_cnt = st_r.pre_cnt + 4'h1;
            end
        end

        // Pulse width measured in fast-acquire intervals; applied to the next pulse
        st_nxt.was_active = pfd_active;
        if (pfd_active) begin
            if (fa_tick && st_r.width_t != sdb_pkg::FA_LEVEL_MAX) begin
                st_nxt.width_t = st_r.width_t + 3'h1;
            end
        end else begin
            st_nxt.width_t = 3'h0;
            if (st_r.was_active) begin
                st_nxt.fa_level = st_r.width_t;
            end
        end
        if (!st_r.cfg.fast || synth_off) begin
            st_nxt.fa_level = 3'h0;
            st_nxt.width_t  = 3'h0;
        end

        // Pump floats in standby and only drives while the detector is active
        st_nxt.pump.oe     = !st_nxt.cfg.pdown[sdb_pkg::PD_MIXER];
        st_nxt.pump.source = st_nxt.pump.oe && (st_r.cfg.invert ? pfd_dn : pfd_up);
        st_nxt.pump.sink   = st_nxt.pump.oe && (st_r.cfg.invert ? pfd_up : pfd_dn);
        st_nxt.pump.units  = pump_units(st_nxt.cfg.code, st_nxt.cfg.fast, st_nxt.fa_level);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r <= st_rst;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata         = st_r.rdata;
    assign mixer_pump_output = st_r.pump;
    assign standby           = st_r.sb;
    assign pin_oe            = st_r.pin_oe;

    a_pdown_reset_ones: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(sys_rst) |-> (st_r.cfg.pdown == sdb_pkg::PDOWN_RST && standby.master_ref_standby))
        else $error("power-down register not all ones after reset");
    a_pdown_write_takes: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ce && reg_wr && reg_addr == sdb_pkg::ADDR_PDOWN) |=> (st_r.cfg.pdown == $past(reg_wdata)))
        else $error("power-down write not stored");
    a_pump_float: assert property (@(posedge clk_sys) disable iff (sys_rst)
        st_r.cfg.pdown[sdb_pkg::PD_MIXER] |-> (!mixer_pump_output.oe
            && !mixer_pump_output.source && !mixer_pump_output.sink))
        else $error("pump drives while synthesizer is in standby");
    a_clkbuf_both_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
        standby.clock_buffer_off == (st_r.cfg.pdown[sdb_pkg::PD_SAMPLE]
            && st_r.cfg.pdown[sdb_pkg::PD_CONV]))
        else $error("clock buffer state wrong");
    a_front_caps_float: assert property (@(posedge clk_sys) disable iff (sys_rst)
        st_r.cfg.pdown[sdb_pkg::PD_FRONT] |-> !(pin_oe.front_end_cap_a_oe
            || pin_oe.front_end_cap_b_oe || pin_oe.front_end_cap_c_oe))
        else $error("front-end capacitor pins driven in standby");
    a_master_ref_all: assert property (@(posedge clk_sys) disable iff (sys_rst)
        standby.master_ref_standby == (&st_r.cfg.pdown[7:2] && st_r.cfg.pdown[sdb_pkg::PD_CONV]))
        else $error("master reference standby wrong");
    a_prescale_nine: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ce && !reg_wr && !synth_off && vco_evt && st_r.swallow_left != 3'h0
            && st_r.pre_cnt == 4'h7) |=> (st_r.pre_cnt == 4'h8))
        else $error("prescaler did not divide by nine");
    a_prescale_eight: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ce && !reg_wr && !synth_off && vco_evt && st_r.swallow_left == 3'h0
            && st_r.pre_cnt == 4'h7) |=> (st_r.pre_cnt == 4'h0))
        else $error("prescaler did not divide by eight");
    a_fb_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ce && !reg_wr && !synth_off && vco_evt && pre_end && main_end)
            |=> (st_r.fb_evt && st_r.main_left == $past(st_r.cfg.main)
                 && st_r.swallow_left == $past(st_r.cfg.swallow)))
        else $error("feedback counters did not reload");
    a_pump_nominal: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ce && !reg_wr && !st_r.cfg.fast)
            |=> (mixer_pump_output.units == {1'b0, $past(st_r.cfg.code)} + 4'h1))
        else $error("pump units differ from code plus one");
    a_fast_floor: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ce && !reg_wr && st_r.cfg.fast)
            |=> (mixer_pump_output.units >= 4'h2
                 && mixer_pump_output.units > {1'b0, $past(st_r.cfg.code)}))
        else $error("fast acquire lowered the pump current");
endmodule

// ---- sdb_osc_model.sv ----
// Reference oscillator and VCO model driving the synthesizer input pins
`timescale 1ns/1ns
module sdb_osc_model #(
    parameter int REF_HALF = 30,
    parameter int VCO_HALF = 40
) (
    // Run controls
    input  wire logic ref_run,
    input  wire logic vco_run,
    // Oscillator pins and rising edge tally
    output logic      ref_in,
    output logic      vco_in,
    output int        vco_edges
);
    // A stopped oscillator parks low so no stray edge reaches the counters
    initial begin
        ref_in = 1'b0;
        forever begin
            #REF_HALF ref_in = ref_run & ~ref_in;
        end
    end
    initial begin
        vco_in = 1'b0;
        vco_edges = 0;
        forever begin
            #VCO_HALF vco_in = vco_run & ~vco_in;
            if (vco_in) vco_edges++;
        end
    end
endmodule

// ---- tb_top.sv ----
// Register level regression of the synthesizer core with an oscillator model
`timescale 1ns/1ns
module tb_top;
    logic                  clk_sys = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  ce = 1'b1;
    logic                  reg_wr = 1'b0;
    logic [7:0]            reg_addr = 8'h00;
    logic [7:0]            reg_wdata = 8'h00;
    logic [7:0]            reg_rdata, d, w;
    logic [18:0]           e;
    logic                  ref_in, vco_in;
    logic                  ref_run = 1'b0;
    logic                  vco_run = 1'b0;
    int                    vco_edges, n;
    int                    err_total = 0;
    int                    num_checks = 0;
    sdb_pkg::sdb_pump_type    pump;
    sdb_pkg::sdb_standby_type sb;
    sdb_pkg::sdb_pin_oe_type  oe;
    localparam logic [7:0] RA [9] = '{8'h00, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
                                      8'h10};
    localparam logic [7:0] RV [9] = '{8'hff, 8'h00, 8'h38, 8'ha0, 8'h1d, 8'h00, 8'h00, 8'h04,
                                      8'h00};

    always #5 clk_sys = ~clk_sys;

    sdb_synth dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ref_in(ref_in),
        .vco_in(vco_in), .mixer_pump_output(pump), .standby(sb), .pin_oe(oe));
    sdb_osc_model osc (.ref_run(ref_run), .vco_run(vco_run), .ref_in(ref_in),
        .vco_in(vco_in), .vco_edges(vco_edges));

    // Standby levels, pin enables and pump enable for a power-down value
    function automatic logic [18:0] exp_pd(input logic [7:0] v);
        return {v[7], v[6], v[5], v[4], v[3], v[2], v[0], v[0], v[0], v[4] & v[0],
                &{v[7:2], v[0]}, ~v[4], ~v[3], ~v[3], ~v[2], ~v[2], ~v[2], ~v[0], ~v[6]};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_sys);
        reg_addr <= a;
        @(posedge clk_sys);
        #1 q = reg_rdata;
    endtask

    task automatic wait_pump(input logic want_sink);
        int k;
        k = 0;
        while ((want_sink ? pump.sink : pump.source) !== 1'b1 && k < 4000) begin
            @(posedge clk_sys);
            #1 k++;
        end
        if (k == 4000) begin
            err_total++;
            $display("BAD pump wait exp 1 got timeout");
            finish_test();
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(RA[i], d);
            chk("reset reg", RV[i], d);
        end
        chk("reset pins", exp_pd(8'hff), {sb, oe, pump.oe});
        chk("reset units", 1, pump.units);
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(sdb_pkg::ADDR_PDOWN, 8'h00);
        ce <= 1'b1;
        rd(sdb_pkg::ADDR_PDOWN, d);
        chk("gated write", 8'hff, d);
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            w = (i < 8) ? ~(8'h01 << i) : ((i == 9) ? 8'hff : 8'h00);
            wr(sdb_pkg::ADDR_PDOWN, w);
            rd(sdb_pkg::ADDR_PDOWN, d);
            chk("pdown", w, d);
            e = exp_pd(w);
            chk("standby", e[18:8], sb);
            chk("pin enables", e[7:0], {oe, pump.oe});
        end
        $display("test standby done");
        // Small divide ratios keep the loop test short: reference by 2, feedback N of 25
        wr(sdb_pkg::ADDR_REF_LO, 8'h02);
        wr(sdb_pkg::ADDR_CNT_HI, 8'h20);
        wr(sdb_pkg::ADDR_MAIN_LO, 8'h03);
        wr(sdb_pkg::ADDR_PDOWN, 8'hbf);
        for (int c = 0; c < 8; c++) begin
            wr(sdb_pkg::ADDR_PUMP, {3'h0, c[2:0], 2'h0});
            repeat (2) @(posedge clk_sys);
            chk("units", c + 1, pump.units);
        end
        wr(sdb_pkg::ADDR_PUMP, 8'h40);
        repeat (2) @(posedge clk_sys);
        chk("fast units", 2, pump.units);
        $display("test pump done");
        n = vco_edges;
        vco_run <= 1'b1;
        wait_pump(1'b1);
        chk("fb edges", 25, vco_edges - n);
        chk("no up", 0, pump.source);
        vco_run <= 1'b0;
        ref_run <= 1'b1;
        wait_pump(1'b0);
        chk("no down", 0, pump.sink);
        ref_run <= 1'b0;
        // Detector still holds up; the invert bit must route it to the sink side
        wr(sdb_pkg::ADDR_PUMP, 8'h20);
        repeat (2) @(posedge clk_sys);
        chk("inverted pump", 2'b01, {pump.source, pump.sink});
        wr(sdb_pkg::ADDR_PDOWN, 8'hff);
        repeat (2) @(posedge clk_sys);
        chk("pump off", 0, {pump.source, pump.sink, pump.oe});
        $display("test loop done");
        finish_test();
    end
endmodule
